/* test/wel_host_model.sv */
// Host-side pin model: wake pulse and shared data pin
`timescale 1ns/1ps
`default_nettype none
module wel_host_model (
    // Clock and commands from the bench
    input  wire logic clk,
    input  wire logic wakeReq,
    input  wire logic selLow,
    input  wire logic txLevel,
    // Pins toward the device
    output logic      extWakeInN,
    output logic      dataPinIn
);
    logic [2:0] lowCnt = 3'h0;

    initial extWakeInN = 1'b1;
    initial dataPinIn = 1'b1;

    always @(posedge clk) begin
        if (wakeReq)
            lowCnt <= 3'h4;
        else if (lowCnt != 3'h0)
            lowCnt <= lowCnt - 3'h1;
        extWakeInN <= !(wakeReq || lowCnt > 3'h1);  // Low-going wake pulse
        dataPinIn  <= selLow ? 1'b0 : txLevel;      // Select low or direct data
    end
endmodule
`default_nettype wire

/* test/wel_wakeup_pin_logic_test.sv */
// Self-checking bench for the wake-up, event and pin-mode logic
`timescale 1ns/1ps
`default_nettype none
module wel_wakeup_pin_logic_test;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    wel_pkg::wel_bus_t bus = '0;
    logic [15:0]       rdata;
    logic              irqOutN, hostClkOut, hostResetOutN, extWakeInN;
    logic              validDataFlag, validDataOe, dataPinIn, dataPinOut, dataPinOe;
    logic              rxBitClockOut, fifoLevelIrq, txBitOut;
    logic              rxBitIn = 1'b0;
    logic              dataQualityIn = 1'b0;
    logic [3:0]        supplyLevel = 4'hF;
    logic              wakeReq = 1'b0;
    logic              selLow = 1'b0;
    logic              txLevel = 1'b0;
    int                numErrors = 0;
    int                compares = 0;
    logic [2:0]        mon;

    assign mon = {rxBitClockOut, txBitOut, hostClkOut};

    wel_wakeup_pin_logic #(.CAL_CYCLES(8), .MS_CYCLES(16)) i_dut (
        .clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
        .irqOutN(irqOutN), .hostClkOut(hostClkOut), .hostResetOutN(hostResetOutN),
        .extWakeInN(extWakeInN), .validDataFlag(validDataFlag),
        .validDataOe(validDataOe), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
        .dataPinOe(dataPinOe), .rxBitClockOut(rxBitClockOut),
        .fifoLevelIrq(fifoLevelIrq), .rxBitIn(rxBitIn), .dataQualityIn(dataQualityIn),
        .supplyLevel(supplyLevel), .txBitOut(txBitOut)
    );

    wel_host_model i_host (
        .clk(clk), .wakeReq(wakeReq), .selLow(selLow), .txLevel(txLevel),
        .extWakeInN(extWakeInN), .dataPinIn(dataPinIn)
    );

    initial forever #25 clk = ~clk;

    task automatic stop_test;
        if (numErrors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Counts rising edges, or high cycles when lvl is set
    task automatic count(input int k, input int n, input bit lvl, output int c);
        logic p;
        c = 0;
        #1;
        p = mon[k];
        repeat (n) begin
            @(posedge clk);
            #1;
            if (lvl ? mon[k] : (mon[k] && !p))
                c++;
            p = mon[k];
        end
    endtask

    task automatic waitIrq(input int n, output int c);
        c = 0;
        while (irqOutN !== 1'b0 && c < n) begin
            cyc(1);
            c++;
        end
    endtask

    task automatic t_reset;
        logic [3:0]  ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hB};
        logic [15:0] rv [8] = '{16'h0003, 16'h0001, 16'h0000, 16'h0000,
                                16'h0000, 16'h0008, 16'h000F, 16'h0000};
        logic [15:0] d;
        int          c;
        chk("irq idle", 16'h0001, {15'h0, irqOutN});
        chk("host reset", 16'h0000, {15'h0, hostResetOutN});
        c = 0;
        while (hostResetOutN !== 1'b1 && c < 40) begin
            cyc(1);
            c++;
        end
        chk("host reset len", 16'h0001, {15'h0, c inside {[14:19]}});
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], d);
            chk("reset value", rv[i], d);
        end
    endtask

    task automatic t_events;
        logic [15:0] d;
        int          c;
        wr(4'hA, 16'h0001);
        waitIrq(6, c);
        chk("serial irq", 16'h0000, {15'h0, irqOutN});
        @(posedge clk) wakeReq <= 1'b1;
        @(posedge clk) wakeReq <= 1'b0;
        cyc(10);
        chk("irq held", 16'h0000, {15'h0, irqOutN});
        rd(4'h7, d);
        chk("event sources", 16'h0011, d & 16'h001F);
        cyc(1);
        chk("irq cleared", 16'h0001, {15'h0, irqOutN});
        rd(4'h7, d);
        chk("events cleared", 16'h0000, d & 16'h001F);
        wr(4'h3, 16'h0005);
        wr(4'h0, 16'h000B);
        @(posedge clk) supplyLevel <= 4'h3;
        waitIrq(10, c);
        rd(4'h7, d);
        chk("low supply", 16'h0104, d & 16'h011F);
        @(posedge clk) supplyLevel <= 4'hF;
        cyc(4);
        wr(4'h0, 16'h0003);
        @(posedge clk) supplyLevel <= 4'h3;
        cyc(10);
        chk("detector off", 16'h0001, {15'h0, irqOutN});
        @(posedge clk) supplyLevel <= 4'hF;
    endtask

    task automatic t_timer;
        logic [15:0] d;
        int          c;
        wr(4'h1, 16'h0002);
        wr(4'h0, 16'h0007); // Crystal already running
        waitIrq(80, c);
        chk("first timeout", 16'h0001, {15'h0, c inside {[36:46]}});
        rd(4'h7, d);
        chk("timer event", 16'h0002, d & 16'h001F);
        waitIrq(80, c);
        chk("period", 16'h0001, {15'h0, c inside {[26:34]}});
        wr(4'h0, 16'h0003);
        rd(4'h7, d);
    endtask

    task automatic t_clock;
        int n;
        wr(4'h0, 16'h0002);
        count(0, 600, 1'b0, n);
        chk("clock tail", 16'h00C0, n[15:0]);
        wr(4'h0, 16'h0001);
        count(0, 50, 1'b0, n);
        chk("clock off", 16'h0000, n[15:0]);
        wr(4'h0, 16'h0003);
        wr(4'h4, 16'h0001);
        count(0, 400, 1'b0, n);
        chk("divided clock", 16'h0001, {15'h0, n inside {[99:101]}});
    endtask

    task automatic t_tx;
        int n;
        wr(4'h6, 16'h0003);
        wr(4'h0, 16'h0013);
        @(posedge clk) selLow <= 1'b1;
        cyc(4);
        wr(4'h8, 16'h000F);
        wr(4'h8, 16'h00F0);
        count(1, 200, 1'b1, n);
        chk("tx stream", 16'h0020, n[15:0]);
        @(posedge clk) selLow <= 1'b0;
        txLevel <= 1'b1;
        cyc(4);
        wr(4'h8, 16'h00FF);
        count(1, 100, 1'b1, n);
        chk("tx refused", 16'h0000, n[15:0]);
        wr(4'h0, 16'h0003);
        @(posedge clk) txLevel <= 1'b1;
        cyc(8);
        chk("direct tx", 16'h0001, {15'h0, txBitOut});
        @(posedge clk) txLevel <= 1'b0;
        cyc(8);
        chk("direct tx", 16'h0000, {15'h0, txBitOut});
    endtask

    task automatic t_rx;
        logic [15:0] d;
        int          n;
        @(posedge clk) rxBitIn <= 1'b1;
        txLevel <= 1'b1;
        wr(4'h0, 16'h0043);
        count(2, 40, 1'b0, n);
        chk("rx clock", 16'h0001, {15'h0, n inside {[9:11]}});
        chk("rx data", 16'h0003, {14'h0, dataPinOe, dataPinOut});
        wr(4'h5, 16'h0001);
        wr(4'h6, 16'h00FF);
        cyc(4);
        wr(4'h0, 16'h0063);
        cyc(3);
        chk("fifo empty", 16'h0001, {14'h0, dataPinOe, fifoLevelIrq});
        wr(4'h5, 16'h0008);
        wr(4'h6, 16'h0000);
        cyc(300);
        chk("fifo level", 16'h0001, {15'h0, fifoLevelIrq});
        rd(4'h7, d);
        chk("fifo event", 16'h0008, d & 16'h0008);
        rd(4'h9, d);
        chk("rx refused", 16'h0000, d);
        @(posedge clk) selLow <= 1'b1;
        cyc(4);
        rd(4'h9, d);
        chk("rx byte", 16'h00FF, d & 16'h00FF);
        @(posedge clk) selLow <= 1'b0;
        @(posedge clk) dataQualityIn <= 1'b1;
        wr(4'h0, 16'h0083);
        cyc(6);
        chk("valid flag", 16'h0003, {14'h0, validDataOe, validDataFlag});
        @(posedge clk) dataQualityIn <= 1'b0;
        cyc(6);
        chk("valid flag", 16'h0002, {14'h0, validDataOe, validDataFlag});
    endtask

    initial begin
        #(50 * 10000);
        numErrors++;
        stop_test;
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset;
        t_events;
        t_timer;
        t_clock;
        t_tx;
        t_rx;
        stop_test;
    end
endmodule
`default_nettype wire

/* verilog/wel_defines.svh */
// Constants for the wake-up, event and pin-mode logic
`ifndef WEL_DEFINES_SVH
`define WEL_DEFINES_SVH

`define WEL_ADDR_W        4
`define WEL_DATA_W        16
`define WEL_REG_CTRL      4'h0
`define WEL_REG_WK_LO     4'h1
`define WEL_REG_WK_HI     4'h2
`define WEL_REG_LOWBAT    4'h3
`define WEL_REG_CLKDIV    4'h4
`define WEL_REG_FLEVEL    4'h5
`define WEL_REG_BITRATE   4'h6
`define WEL_REG_STATUS    4'h7
`define WEL_REG_TXDATA    4'h8
`define WEL_REG_RXDATA    4'h9
`define WEL_REG_WAKEREQ   4'hA

`define WEL_CTRL_RST      8'h03
`define WEL_WK_RST        32'h0000_0001
`define WEL_LOWBAT_RST    4'h0
`define WEL_CLKDIV_RST    3'h0
`define WEL_FLEVEL_RST    5'h08
`define WEL_BITRATE_RST   8'h0F

`define WEL_EV_EXT        0
`define WEL_EV_TIMER      1
`define WEL_EV_LOWBAT     2
`define WEL_EV_FIFO       3
`define WEL_EV_SERIAL     4

`define WEL_CLK_NS        50
`define WEL_CAL_NS        500000
`define WEL_MS_NS         1000000
`define WEL_CAL_CYCLES    ((`WEL_CAL_NS + `WEL_CLK_NS - 1) / `WEL_CLK_NS)
`define WEL_MS_CYCLES     (`WEL_MS_NS / `WEL_CLK_NS)
`define WEL_TAIL_PULSES   8'd192
`define WEL_RSTOUT_CYCLES 4'hF
`define WEL_FIFO_BITS     5'h10

`endif

/* verilog/wel_pkg.sv */
// Types for the wake-up, event and pin-mode logic
package wel_pkg;

    typedef enum logic [1:0] {WT_OFF, WT_CAL, WT_RUN} wel_wt_state_t;

    typedef struct packed {
        logic vdiSelect;
        logic rxMode;
        logic rxQueueEnable;
        logic txBufferEnable;
        logic lowBatEn;
        logic wkupEn;
        logic clkOutEn;
        logic xtalOn;
    } wel_ctrl_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } wel_bus_t;

    typedef struct packed {
        wel_ctrl_t     ctrl;
        logic [31:0]   wkPeriod;
        logic [3:0]    lowBatThr;
        logic [2:0]    clkDiv;
        logic [4:0]    fifoLevel;
        logic [7:0]    bitRate;
        logic          extS1;
        logic          extS2;
        logic          extPrev;
        logic          dataS1;
        logic          dataS2;
        logic          dqdS1;
        logic          dqdS2;
        logic          rxS1;
        logic          rxS2;
        logic [3:0]    supS1;
        logic [3:0]    supS2;
        logic          lowPrev;
        logic [4:0]    events;
        wel_wt_state_t wtState;
        logic [19:0]   wtPre;
        logic [31:0]   wtMs;
        logic [2:0]    clkCnt;
        logic          clkLvl;
        logic [7:0]    tailCnt;
        logic [7:0]    brCnt;
        logic [15:0]   fifo;
        logic [4:0]    fifoCnt;
        logic [7:0]    txBuf0;
        logic [7:0]    txBuf1;
        logic          txV0;
        logic          txV1;
        logic [2:0]    txIdx;
        logic [3:0]    rstCnt;
        logic [15:0]   rdata;
        logic          irqN;
        logic          hostClk;
        logic          hostRstN;
        logic          dataOut;
        logic          dataOe;
        logic          bitClk;
        logic          fifo_level_irq;
        logic          valid_data_flag;
        logic          vdiOe;
        logic          txBit;
    } wel_state_t;

endpackage

/* verilog/wel_wakeup_pin_logic.sv */
// Wake-up timer, event latch, clock tail and shared data-pin logic
`timescale 1ns/1ps
`default_nettype none
`include "wel_defines.svh"

module wel_wakeup_pin_logic #(
    parameter int CAL_CYCLES = `WEL_CAL_CYCLES,
    parameter int MS_CYCLES  = `WEL_MS_CYCLES
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Register port
    input  wire wel_pkg::wel_bus_t bus,
    output logic [15:0]           rdata,
    // Host side pins
    output logic                  irqOutN,
    output logic                  hostClkOut,
    output logic                  hostResetOutN,
    input  wire logic             extWakeInN,
    output logic                  validDataFlag,
    output logic                  validDataOe,
    input  wire logic             dataPinIn,
    output logic                  dataPinOut,
    output logic                  dataPinOe,
    output logic                  rxBitClockOut,
    output logic                  fifoLevelIrq,
    // Transceiver core side
    input  wire logic             rxBitIn,
    input  wire logic             dataQualityIn,
    input  wire logic [3:0]       supplyLevel,
    output logic                  txBitOut
);

    wel_pkg::wel_state_t st;
    wel_pkg::wel_state_t next_st;

    always_comb begin
        logic        tick;
        logic        rdStat;
        logic        bufSel;
        logic        popOk;
        logic        lowNow;
        logic [4:0]  ev;
        logic [15:0] shifted;
        logic [31:0] per;
        tick    = 1'b0;
        rdStat  = 1'b0;
        bufSel  = 1'b0;
        popOk   = 1'b0;
        lowNow  = 1'b0;
        ev      = 5'h00;
        shifted = 16'h0000;
        per     = 32'h0000_0000;
        next_st = st;

        // Input synchronisers
        next_st.extS1 = extWakeInN;
        next_st.extS2 = st.extS1;
        next_st.extPrev = st.extS2;
        next_st.dataS1 = dataPinIn;
        next_st.dataS2 = st.dataS1;
        next_st.dqdS1 = dataQualityIn;
        next_st.dqdS2 = st.dqdS1;
        next_st.rxS1 = rxBitIn;
        next_st.rxS2 = st.rxS1;
        next_st.supS1 = supplyLevel;
        next_st.supS2 = st.supS1;
        bufSel = !st.dataS2;

        // Register writes; config only changes here
        if (bus.wr) begin
            case (bus.addr)
                `WEL_REG_CTRL:    next_st.ctrl = wel_pkg::wel_ctrl_t'(bus.wdata[7:0]);
                `WEL_REG_WK_LO:   next_st.wkPeriod[15:0] = bus.wdata;
                `WEL_REG_WK_HI:   next_st.wkPeriod[31:16] = bus.wdata;
                `WEL_REG_LOWBAT:  next_st.lowBatThr = bus.wdata[3:0];
                `WEL_REG_CLKDIV:  next_st.clkDiv = bus.wdata[2:0];
                `WEL_REG_FLEVEL:  next_st.fifoLevel = bus.wdata[4:0];
                `WEL_REG_BITRATE: next_st.bitRate = bus.wdata[7:0];
                `WEL_REG_WAKEREQ: ev[`WEL_EV_SERIAL] = 1'b1;
                default: ;
            endcase
        end

        // Bit-rate generator
        if (st.brCnt >= st.bitRate) begin
            next_st.brCnt = 8'h00;
            tick = 1'b1;
        end else begin
            next_st.brCnt = st.brCnt + 8'h01;
        end

        // Wake-up timer with calibration
        per = (st.wkPeriod == 32'h0) ? 32'h1 : st.wkPeriod;
        case (st.wtState)
            wel_pkg::WT_OFF: begin
                next_st.wtPre = 20'h00000;
                if (st.ctrl.wkupEn && st.ctrl.xtalOn) begin
                    next_st.wtState = wel_pkg::WT_CAL;
                end
            end
            wel_pkg::WT_CAL: begin
                if (!st.ctrl.wkupEn) begin
                    next_st.wtState = wel_pkg::WT_OFF;
                end else if (st.wtPre == 20'(CAL_CYCLES - 1)) begin
                    next_st.wtState = wel_pkg::WT_RUN;
                    next_st.wtPre = 20'h00000;
                    next_st.wtMs = 32'h0;
                end else begin
                    next_st.wtPre = st.wtPre + 20'h00001;
                end
            end
            wel_pkg::WT_RUN: begin
                if (!st.ctrl.wkupEn) begin
                    next_st.wtState = wel_pkg::WT_OFF;
                end else if (st.wtPre == 20'(MS_CYCLES - 1)) begin
                    next_st.wtPre = 20'h00000;
                    if (st.wtMs + 32'h1 >= per) begin
                        next_st.wtMs = 32'h0;
                        ev[`WEL_EV_TIMER] = 1'b1;
                    end else begin
                        next_st.wtMs = st.wtMs + 32'h1;
                    end
                end else begin
                    next_st.wtPre = st.wtPre + 20'h00001;
                end
            end
            default: next_st.wtState = wel_pkg::WT_OFF;
        endcase

        // External wake pin, only while the shared pin is an input
        if (!st.ctrl.vdiSelect && st.extPrev && !st.extS2) begin
            ev[`WEL_EV_EXT] = 1'b1;
        end

        // Low-supply detector
        lowNow = st.ctrl.lowBatEn && st.lowPrev;
        if (st.supS1 == st.supS2) begin // Skewed supply code ignored until settled
            lowNow = st.ctrl.lowBatEn && (st.supS2 < st.lowBatThr);
        end
        next_st.lowPrev = lowNow;
        if (lowNow && !st.lowPrev) begin
            ev[`WEL_EV_LOWBAT] = 1'b1;
        end

        // Transmit buffers
        if (!st.ctrl.rxMode && st.ctrl.txBufferEnable) begin
            if (tick && st.txV0) begin
                next_st.txBit = st.txBuf0[7];
                next_st.txBuf0 = {st.txBuf0[6:0], 1'b0};
                next_st.txIdx = st.txIdx + 3'h1;
                if (st.txIdx == 3'h7) begin
                    next_st.txV0 = st.txV1;
                    next_st.txBuf0 = st.txBuf1;
                    next_st.txV1 = 1'b0;
                end
            end
            if (bus.wr && bus.addr == `WEL_REG_TXDATA && bufSel) begin
                if (!next_st.txV0) begin
                    next_st.txBuf0 = bus.wdata[7:0];
                    next_st.txV0 = 1'b1;
                    next_st.txIdx = 3'h0;
                end else if (!next_st.txV1) begin
                    next_st.txBuf1 = bus.wdata[7:0];
                    next_st.txV1 = 1'b1;
                end
            end
        end else if (!st.ctrl.rxMode) begin
            next_st.txBit = st.dataS2;
        end

        // Receive FIFO and pop
        popOk = bus.rd && bus.addr == `WEL_REG_RXDATA && st.ctrl.rxQueueEnable
                && bufSel && st.fifoCnt >= 5'h08;
        if (popOk) begin
            next_st.fifoCnt = st.fifoCnt - 5'h08;
        end
        shifted = st.fifo >> (st.fifoCnt - 5'h08);
        if (st.ctrl.rxMode && st.ctrl.rxQueueEnable && tick
            && next_st.fifoCnt < `WEL_FIFO_BITS) begin
            next_st.fifo = {st.fifo[14:0], st.rxS2};
            next_st.fifoCnt = next_st.fifoCnt + 5'h01;
        end

        // Shared pins per mode
        next_st.dataOe = st.ctrl.rxMode && !st.ctrl.rxQueueEnable;
        next_st.dataOut = next_st.dataOe ? st.rxS2 : 1'b0;
        next_st.bitClk = next_st.dataOe && (st.brCnt <= (st.bitRate >> 1));
        next_st.fifo_level_irq = 1'b0;
        if (st.ctrl.rxMode && st.ctrl.rxQueueEnable) begin
            if (st.fifoLevel == 5'h01) begin
                next_st.fifo_level_irq = (next_st.fifoCnt == 5'h00);
            end else begin
                next_st.fifo_level_irq = (next_st.fifoCnt >= st.fifoLevel);
            end
        end
        if (next_st.fifo_level_irq && !st.fifo_level_irq) begin
            ev[`WEL_EV_FIFO] = 1'b1;
        end
        next_st.vdiOe = st.ctrl.vdiSelect;
        next_st.valid_data_flag = st.ctrl.vdiSelect && st.dqdS2;

        // Host clock with a tail after crystal switch-off
        if (st.ctrl.xtalOn && !next_st.ctrl.xtalOn && st.ctrl.clkOutEn) begin
            next_st.tailCnt = `WEL_TAIL_PULSES;
        end
        if (st.ctrl.xtalOn || st.tailCnt != 8'h00) begin
            if (st.clkCnt >= st.clkDiv) begin
                next_st.clkCnt = 3'h0;
                next_st.clkLvl = !st.clkLvl;
                if (!st.clkLvl && !st.ctrl.xtalOn && st.tailCnt != 8'h00) begin
                    next_st.tailCnt = st.tailCnt - 8'h01;
                end
            end else begin
                next_st.clkCnt = st.clkCnt + 3'h1;
            end
        end else begin
            next_st.clkLvl = 1'b0;
            next_st.clkCnt = 3'h0;
        end
        next_st.hostClk = next_st.clkLvl && next_st.ctrl.clkOutEn;

        // Host reset output
        if (st.rstCnt != 4'h0) begin
            next_st.rstCnt = st.rstCnt - 4'h1;
        end
        next_st.hostRstN = (next_st.rstCnt == 4'h0);

        // Event latch; a new event wins over the clearing read
        rdStat = bus.rd && bus.addr == `WEL_REG_STATUS;
        next_st.events = (rdStat ? 5'h00 : st.events) | ev;
        next_st.irqN = !(|next_st.events);

        // Read data; held between reads
        if (bus.rd) begin
            case (bus.addr)
                `WEL_REG_CTRL:    next_st.rdata = {8'h00, st.ctrl};
                `WEL_REG_WK_LO:   next_st.rdata = st.wkPeriod[15:0];
                `WEL_REG_WK_HI:   next_st.rdata = st.wkPeriod[31:16];
                `WEL_REG_LOWBAT:  next_st.rdata = {12'h000, st.lowBatThr};
                `WEL_REG_CLKDIV:  next_st.rdata = {13'h0000, st.clkDiv};
                `WEL_REG_FLEVEL:  next_st.rdata = {11'h000, st.fifoLevel};
                `WEL_REG_BITRATE: next_st.rdata = {8'h00, st.bitRate};
                `WEL_REG_STATUS:  next_st.rdata = {1'b0, st.fifoCnt, st.dqdS2, st.lowPrev,
                                      st.wtState == wel_pkg::WT_RUN, st.txV1, st.txV0,
                                      st.events};
                `WEL_REG_RXDATA:  next_st.rdata = popOk ? {8'h00, shifted[7:0]} : 16'h0000;
                default:          next_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= `WEL_CTRL_RST;
            st.wkPeriod <= `WEL_WK_RST;
            st.lowBatThr <= `WEL_LOWBAT_RST;
            st.clkDiv <= `WEL_CLKDIV_RST;
            st.fifoLevel <= `WEL_FLEVEL_RST;
            st.bitRate <= `WEL_BITRATE_RST;
            st.extS1 <= 1'b1;
            st.extS2 <= 1'b1;
            st.extPrev <= 1'b1;
            st.dataS1 <= 1'b1;
            st.dataS2 <= 1'b1;
            st.wtState <= wel_pkg::WT_OFF;
            st.rstCnt <= `WEL_RSTOUT_CYCLES;
            st.irqN <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rdata         = st.rdata;
    assign irqOutN       = st.irqN;
    assign hostClkOut    = st.hostClk;
    assign hostResetOutN = st.hostRstN;
    assign validDataFlag = st.valid_data_flag;
    assign validDataOe   = st.vdiOe;
    assign dataPinOut    = st.dataOut;
    assign dataPinOe     = st.dataOe;
    assign rxBitClockOut = st.bitClk;
    assign fifoLevelIrq  = st.fifo_level_irq;
    assign txBitOut      = st.txBit;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_irq_active_low: assert property (irqOutN == !(|st.events))
        else $error("irq level does not match latched events");
    a_status_report: assert property (ce && bus.rd && bus.addr == `WEL_REG_STATUS
        |=> rdata[4:0] == $past(st.events))
        else $error("status read did not return event sources");
    a_events_latched: assert property (ce && !(bus.rd && bus.addr == `WEL_REG_STATUS)
        |=> (st.events & $past(st.events)) == $past(st.events))
        else $error("pending event lost without status read");
    a_cal_length: assert property ($rose(st.wtState == wel_pkg::WT_RUN)
        |-> $past(st.wtPre) == 20'(CAL_CYCLES - 1))
        else $error("calibration did not last its full time");
    a_tail_load: assert property (ce && st.ctrl.xtalOn && st.ctrl.clkOutEn && bus.wr
        && bus.addr == `WEL_REG_CTRL && !bus.wdata[0]
        |=> st.tailCnt == `WEL_TAIL_PULSES)
        else $error("clock tail not loaded on crystal off");
    a_tx_direct: assert property (ce && !st.ctrl.rxMode && !st.ctrl.txBufferEnable
        |=> txBitOut == $past(st.dataS2))
        else $error("direct transmit data not passed through");
    a_fifo_level_irq_empty: assert property (st.fifoLevel == 5'h01 && st.ctrl.rxMode
        && st.ctrl.rxQueueEnable && $stable(st.ctrl) && $stable(st.fifoLevel)
        |-> fifoLevelIrq == (st.fifoCnt == 5'h00))
        else $error("fifo irq does not flag empty at level one");
    a_rdata_hold: assert property (!bus.rd |=> $stable(rdata))
        else $error("read data changed without a read");
    a_host_reset: assert property ($past(rst) |-> !hostResetOutN)
        else $error("host reset released too early");
    a_ext_wake: assert property (ce && !st.ctrl.vdiSelect && st.extPrev && !st.extS2
        |=> st.events[`WEL_EV_EXT] && !irqOutN)
        else $error("external wake pulse not latched");
    a_serial_wake: assert property (ce && bus.wr && bus.addr == `WEL_REG_WAKEREQ
        |=> st.events[`WEL_EV_SERIAL] && !irqOutN)
        else $error("serial wake request not latched");
    a_tail_stop: assert property (ce && !st.ctrl.xtalOn && st.tailCnt == 8'h00
        |=> !hostClkOut)
        else $error("host clock ran past its tail");
    a_clk_gate: assert property (ce && !st.ctrl.clkOutEn
        && !(bus.wr && bus.addr == `WEL_REG_CTRL) |=> !hostClkOut)
        else $error("host clock ran while disabled");
    a_lowbat_off: assert property (ce && !st.ctrl.lowBatEn
        |=> !st.events[`WEL_EV_LOWBAT] || $past(st.events[`WEL_EV_LOWBAT]))
        else $error("low supply event while detector off");
    a_data_pin_oe: assert property (ce
        |=> dataPinOe == $past(st.ctrl.rxMode && !st.ctrl.rxQueueEnable))
        else $error("data pin drive does not follow mode");
    a_valid_pin_oe: assert property (ce
        |=> validDataOe == $past(st.ctrl.vdiSelect))
        else $error("valid pin drive does not follow select");
    a_rx_refused: assert property (ce && bus.rd && bus.addr == `WEL_REG_RXDATA
        && !st.ctrl.rxQueueEnable |=> rdata == 16'h0000)
        else $error("receive read returned data with queue off");

    c_timer_event: cover property (ce && st.wtState == wel_pkg::WT_RUN
        ##1 st.events[`WEL_EV_TIMER]);
    c_tail_done: cover property (st.tailCnt == 8'h01 ##[1:20] st.tailCnt == 8'h00);
    c_fifo_pop: cover property (ce && bus.rd && bus.addr == `WEL_REG_RXDATA
        && st.fifoCnt >= 5'h08);
    c_tx_shift: cover property (st.txV0 && st.txV1 ##[1:1000] !st.txV1);
    c_ext_wake: cover property (ce && !st.ctrl.vdiSelect && st.extPrev && !st.extS2
        ##1 !irqOutN);

endmodule
`default_nettype wire
